/* File: shared/lsp_pkg.sv */
// package: constants shared by both ends of the serial load port
package lsp_pkg;
	// frame lengths in serial clocks that select a target, and the count limit
	localparam int unsigned SETUP_CLOCKS = 8;
	localparam int unsigned REF_CLOCKS   = 16;
	localparam int unsigned LOOP_CLOCKS  = 24;
	localparam int unsigned MAX_CLOCKS   = 32;
	// word widths and field positions
	localparam int unsigned SETUP_W      = 8;
	localparam int unsigned REF_W        = 16;
	localparam int unsigned LOOP_W       = 24;
	localparam int unsigned REF_DIV_W    = 13;
	localparam int unsigned REF_MODE_LSB = 13;
	localparam int unsigned REF_MODE_W   = 3;
	localparam int unsigned CNT_W        = 6;
	// reset values
	localparam logic [7:0]  SETUP_RST    = 8'h00;
	localparam logic [15:0] REF_RST      = 16'h0000;
	localparam logic [23:0] LOOP_RST     = 24'h00_0000;
	// host timing: serial clock half period 200 ns, select guard 1000 ns
	localparam int unsigned CLK_NS       = 10;
	localparam int unsigned HALF_NS      = 200;
	localparam int unsigned HALF_CYC     = HALF_NS / CLK_NS;
	localparam int unsigned GUARD_NS     = 1000;
	localparam int unsigned GUARD_CYC    = GUARD_NS / CLK_NS;
	// host register offsets
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_DATA     = 4'h4;
	localparam logic [3:0]  REG_STATUS   = 4'h8;
	// host ctrl write layout: [0] go, [6:1] clock count; a read returns the count in [5:0]
	localparam int unsigned CTRL_GO      = 0;
	localparam int unsigned CTRL_CNT_LSB = 1;
endpackage : lsp_pkg

/* File: shared/lsp_if.sv */
// interface: the three wires between host and serial load port
interface lsp_if;
	logic port_select_n;   // active low frame enable
	logic serial_clock;
	logic serial_data;
	modport device (input port_select_n, input serial_clock, input serial_data);
	modport host   (output port_select_n, output serial_clock, output serial_data);
endinterface : lsp_if

/* File: hdl/lsp_sync.sv */
// three-stage synchroniser with agreement filter for one pin
module lsp_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic pin,
	output logic      level
);
	logic [2:0] s_q;

	// s_q[0] is read only by s_q[1]; level moves once stages 2 and 3 agree
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q   <= {3{RST_VAL}};
			level <= RST_VAL;
		end else begin
			s_q <= {s_q[1:0], pin};
			if (s_q[1] == s_q[2])
				level <= s_q[2];
		end
	end
endmodule : lsp_sync

/* File: hdl/lsp_device.sv */
// device end: shift register, clock counter and target registers
//
// Notes on behaviour
// RULE_01: data msb first, sampled on rising clock
// RULE_02: 8/16/24 clocks pick setup/ref/loop word
// RULE_03: host sends no other count up to 32
// RULE_04: held words stay fixed while shifting
// RULE_05: enable rising edge loads chosen register
// RULE_06: enable high ignores clocks, clears counter
// RULE_07: host moves enable only with clock low
// RULE_08: host keeps main count >= swallow count
// RULE_09: low 13 ref bits double buffered
// RULE_10: top 3 ref bits act immediately
// RULE_11: 24-clock frame also promotes ref stage
// RULE_12: clockless frame promotes ref stage only
// RULE_13: no address bits; any write order
// RULE_14: host holds enable low long enough
// RULE_15: counter saturates above 32, clears idle
// RULE_16: shift keeps last 24 bits received
module lsp_device (
	input  wire logic            clk,
	input  wire logic            nrst,
	lsp_if.device                link,
	output logic [7:0]           setup_word_q,
	output logic [15:0]          ref_word_q,
	output logic [12:0]          ref_count_q,
	output logic [23:0]          loop_word_q,
	output logic                 load_pulse_q
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic sel_n;
	logic sclk;
	logic sdat;
	logic sel_n_q;
	logic sclk_q;
	logic sdat_d1_q;

	// all three pins come from the host's domain; each gets its own filter so
	// a glitch shorter than two clocks never reaches the counter or shifter.
	// the filters share one latency, so clock and data keep their relation
	lsp_sync #(
		.RST_VAL(1'b1)                   // idle level of the enable
	) u_sel (
		.clk  (clk),
		.nrst (nrst),
		.pin  (link.port_select_n),
		.level(sel_n)
	);
	lsp_sync #(
		.RST_VAL(1'b0)                   // idle level of the clock
	) u_clk (
		.clk  (clk),
		.nrst (nrst),
		.pin  (link.serial_clock),
		.level(sclk)
	);
	lsp_sync #(
		.RST_VAL(1'b0)
	) u_dat (
		.clk  (clk),
		.nrst (nrst),
		.pin  (link.serial_data),
		.level(sdat)
	);

	// ****************************************************************
	// edge detection
	// ****************************************************************
	logic clk_rise;
	logic sel_rise;
	logic armed_q;

	// previous enable level; resets high so no false edge follows reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sel_n_q <= 1'b1;
		else
			sel_n_q <= sel_n;
	end

	// previous clock level; resets to the idle low level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sclk_q <= 1'b0;
		else
			sclk_q <= sclk;
	end

	// data delayed one cycle so it lines up with the detected clock edge;
	// the host changes data half a bit before the edge, so either tap works
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sdat_d1_q <= 1'b0;
		else
			sdat_d1_q <= sdat;
	end

	// edges of the filtered levels, each high for one clock
	assign clk_rise = sclk & ~sclk_q;
	assign sel_rise = sel_n & ~sel_n_q;

	// out of sync until enable high with clock low; frames started while
	// unsynchronised are discarded. an enable move seen with the clock high
	// drops the sync, since the host may already be half a bit in
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			armed_q <= 1'b0;
		else if (sel_n && !sclk)
			armed_q <= 1'b1;                 // [RULE_07]
		else if (sel_n_q != sel_n && sclk)
			armed_q <= 1'b0;
	end

	// ****************************************************************
	// shift register and clock counter
	// ****************************************************************
	logic [23:0]            shift_q;
	logic [lsp_pkg::CNT_W-1:0] count_q;

	// msb first, new bit enters at bit 0 so the last bit is the lsb;
	// longer frames push the oldest bits out, and only the last 24 survive,
	// which is all that any target needs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			shift_q <= lsp_pkg::LOOP_RST;
		else if (!sel_n && clk_rise)
			shift_q <= {shift_q[22:0], sdat_d1_q}; // [RULE_01] [RULE_16] [RULE_13]
	end

	// saturate past 32 so long frames never match a target length;
	// a free-running count would wrap at 64 and could alias onto 8, 16
	// or 24 again, loading a word from a cascaded stream
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			count_q <= '0;
		else if (sel_n)
			count_q <= '0;                   // [RULE_06] [RULE_15]
		else if (clk_rise && count_q <= lsp_pkg::CNT_W'(lsp_pkg::MAX_CLOCKS))
			count_q <= count_q + 1'b1;       // [RULE_15]
	end

	// ****************************************************************
	// target registers, touched only at the enable rising edge
	// ****************************************************************
	logic do_load;
	logic is_setup;
	logic is_ref;
	logic is_loop;
	logic is_none;

	// a frame loads only if it began in sync; the length seen at the enable
	// edge picks one target, and a length that matches none still pulses,
	// so a watcher can tell that the frame ended
	assign do_load  = sel_rise && armed_q;   // [RULE_05] [RULE_04]
	assign is_setup = count_q == lsp_pkg::CNT_W'(lsp_pkg::SETUP_CLOCKS);
	assign is_ref   = count_q == lsp_pkg::CNT_W'(lsp_pkg::REF_CLOCKS);
	assign is_loop  = count_q == lsp_pkg::CNT_W'(lsp_pkg::LOOP_CLOCKS);
	assign is_none  = count_q == '0;

	// setup word; like every word below it waits for do_load, so nothing
	// held moves while bits are still being shifted
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			setup_word_q <= lsp_pkg::SETUP_RST;
		else if (do_load && is_setup)
			setup_word_q <= shift_q[7:0];    // [RULE_02]
	end

	// first ref stage; mode bits are used straight from here
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ref_word_q <= lsp_pkg::REF_RST;
		else if (do_load && is_ref)
			ref_word_q <= shift_q[15:0];     // [RULE_02] [RULE_10]
	end

	// second ref stage feeds the reference counter; it moves only with a
	// loop load or an empty frame, so the dividers see new ratios at once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ref_count_q <= lsp_pkg::REF_RST[12:0];
		else if (do_load && (is_loop || is_none))
			ref_count_q <= ref_word_q[12:0]; // [RULE_09] [RULE_11] [RULE_12]
	end

	// loop word
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			loop_word_q <= lsp_pkg::LOOP_RST;
		else if (do_load && is_loop)
			loop_word_q <= shift_q;          // [RULE_02] [RULE_11]
	end

	// one pulse per accepted frame, whatever its length; it comes in the
	// same cycle as the word it marks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			load_pulse_q <= 1'b0;
		else
			load_pulse_q <= do_load;
	end
endmodule : lsp_device

/* File: hdl/lsp_host.sv */
// host end: register port that sends one msb-first frame on command
module lsp_host (
	input  wire logic        clk,
	input  wire logic        nrst,
	lsp_if.host              link,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata_q
);
	typedef enum logic [2:0] {LSP_IDLE, LSP_LEAD, LSP_LOW, LSP_HIGH, LSP_TAIL} lsp_state_t;

	lsp_state_t  state_q;
	logic [23:0] data_q;
	logic [5:0]  len_q;
	logic [5:0]  left_q;
	logic [7:0]  tmr_q;
	logic        sel_n_q;
	logic        sclk_q;
	logic        sdat_q;
	logic        start;
	logic        tmr_done;
	logic [5:0]  req_len;
	logic        len_ok;

	assign link.port_select_n = sel_n_q;
	assign link.serial_clock  = sclk_q;
	assign link.serial_data   = sdat_q;

	// only target lengths, an empty frame or a cascade length past 32 are
	// sent; any other go is dropped, seen only as status staying not busy
	assign req_len  = wdata[lsp_pkg::CTRL_CNT_LSB +: 6];
	assign len_ok   = req_len == 6'h00 || req_len == 6'(lsp_pkg::SETUP_CLOCKS)
		|| req_len == 6'(lsp_pkg::REF_CLOCKS) || req_len == 6'(lsp_pkg::LOOP_CLOCKS)
		|| req_len > 6'(lsp_pkg::MAX_CLOCKS);    // [RULE_03]
	assign start    = wr && addr == lsp_pkg::REG_CTRL && wdata[lsp_pkg::CTRL_GO]
		&& state_q == LSP_IDLE && len_ok;
	assign tmr_done = tmr_q == 8'h00;

	// data and length registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_q <= 24'h00_0000;
			len_q  <= 6'h00;
		end else begin
			if (wr && addr == lsp_pkg::REG_DATA && state_q == LSP_IDLE)
				data_q <= wdata[23:0];
			if (start)
				len_q <= wdata[lsp_pkg::CTRL_CNT_LSB +: 6];
		end
	end

	// read port, data valid the cycle after rd
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdata_q <= 32'h0000_0000;
		else if (rd)
			unique case (addr)
				lsp_pkg::REG_CTRL:   rdata_q <= {26'h000_0000, len_q};
				lsp_pkg::REG_DATA:   rdata_q <= {8'h00, data_q};
				lsp_pkg::REG_STATUS: rdata_q <= {31'h0000_0000, state_q != LSP_IDLE};
				default:             rdata_q <= 32'h0000_0000;
			endcase
		else
			rdata_q <= 32'h0000_0000;
	end

	// frame sequencer; enable only moves while the clock is low [RULE_07]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= LSP_IDLE;
			sel_n_q <= 1'b1;
			sclk_q  <= 1'b0;
			sdat_q  <= 1'b0;
			left_q  <= 6'h00;
			tmr_q   <= 8'h00;
		end else begin
			if (!tmr_done)
				tmr_q <= tmr_q - 8'h01;
			unique case (state_q)
				LSP_IDLE: if (start) begin
					sel_n_q <= 1'b0;
					left_q  <= wdata[lsp_pkg::CTRL_CNT_LSB +: 6];
					tmr_q   <= 8'(lsp_pkg::HALF_CYC);
					state_q <= LSP_LEAD;
				end
				LSP_LEAD, LSP_HIGH: if (tmr_done) begin
					sclk_q <= 1'b0;
					tmr_q  <= 8'(lsp_pkg::HALF_CYC);
					if (left_q == 6'h00) begin
						tmr_q   <= 8'(lsp_pkg::GUARD_CYC); // [RULE_14]
						state_q <= LSP_TAIL;
					end else begin
						// msb of the chosen length goes first [RULE_01]
						// lengths past 24 lead with zeros; the word holds 24 bits
						sdat_q  <= (left_q > 6'(lsp_pkg::LOOP_W)) ? 1'b0
							: data_q[5'(left_q - 6'h01)];
						left_q  <= left_q - 6'h01;
						state_q <= LSP_LOW;
					end
				end
				LSP_LOW: if (tmr_done) begin
					sclk_q  <= 1'b1;
					tmr_q   <= 8'(lsp_pkg::HALF_CYC);
					state_q <= LSP_HIGH;
				end
				LSP_TAIL: if (tmr_done) begin
					sel_n_q <= 1'b1;
					tmr_q   <= 8'(lsp_pkg::GUARD_CYC);
					state_q <= LSP_IDLE;
				end
			endcase
		end
	end
endmodule : lsp_host

/* File: tb/lsp_assertions.sv */
// checker: link wire and device output properties of the serial load port
module lsp_checker (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        port_select_n,
	input wire logic        serial_clock,
	input wire logic        serial_data,
	input wire logic [7:0]  setup_word_q,
	input wire logic [15:0] ref_word_q,
	input wire logic [12:0] ref_count_q,
	input wire logic [23:0] loop_word_q,
	input wire logic        load_pulse_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ************************************************************
	// properties
	// ************************************************************
	property p_hold_while_shift;
		!port_select_n [*8] |-> $stable(setup_word_q) && $stable(ref_word_q) && $stable(loop_word_q);
	endproperty
	a_hold_while_shift: assert property (p_hold_while_shift) else $error("word moved in frame");
	property p_pulse_after_rise;
		$rose(port_select_n) |-> ##[2:8] load_pulse_q;
	endproperty
	a_pulse_after_rise: assert property (p_pulse_after_rise) else $error("no load pulse");
	property p_pulse_one_cycle;
		load_pulse_q |=> !load_pulse_q;
	endproperty
	a_pulse_one_cycle: assert property (p_pulse_one_cycle) else $error("pulse too long");
	property p_setup_at_pulse;
		$changed(setup_word_q) || $changed(ref_word_q) |-> load_pulse_q || $past(load_pulse_q);
	endproperty
	a_setup_at_pulse: assert property (p_setup_at_pulse) else $error("load without pulse");
	property p_count_at_pulse;
		$changed(ref_count_q) |-> load_pulse_q || $past(load_pulse_q);
	endproperty
	a_count_at_pulse: assert property (p_count_at_pulse) else $error("stage two moved alone");
	property p_loop_promotes;
		$changed(loop_word_q) |-> ##[0:1] ref_count_q == ref_word_q[12:0];
	endproperty
	a_loop_promotes: assert property (p_loop_promotes) else $error("stage two not promoted");
	property p_select_clock_low;
		$changed(port_select_n) |-> !serial_clock && !$past(serial_clock);
	endproperty
	a_select_clock_low: assert property (p_select_clock_low) else $error("select moved clock high");
	property p_idle_clock;
		port_select_n |-> !serial_clock;
	endproperty
	a_idle_clock: assert property (p_idle_clock) else $error("clock runs idle");
	property p_data_steady;
		$rose(serial_clock) |-> $stable(serial_data) ##1 ($stable(serial_data) && serial_clock) [*8];
	endproperty
	a_data_steady: assert property (p_data_steady) else $error("data moved at sample");
	// main scenarios seen
	c_load: cover property (load_pulse_q);
	c_clockless: cover property ($changed(ref_count_q) && $stable(loop_word_q));
	c_promote: cover property ($changed(ref_count_q));
endmodule // lsp_checker

/* File: tb/tb.sv */
// testbench: host and device ends joined, frames checked at device outputs
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, wr, rd;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata_q, got;
	logic [7:0]  setup_word_q, es;
	logic [15:0] ref_word_q, er;
	logic [12:0] ref_count_q, ec;
	logic [23:0] loop_word_q, el;
	logic        load_pulse_q;
	int          failures, checks_done, i;
	// count and data of each frame, applied to the model below; 0x0c is a
	// length the host drops loop words keep main >= swallow
	logic [29:0] rows [9] = '{{6'h10, 24'h00_e5c3}, {6'h18, 24'h96_3a5c}, {6'h08, 24'h12_3481},
		{6'h10, 24'hff_3f0f}, {6'h00, 24'h00_0000}, {6'h0c, 24'h00_0aaa},
		{6'h21, 24'hff_ffff}, {6'h18, 24'h5a_0001}, {6'h08, 24'h00_007e}};
	lsp_if link ();
	lsp_host lsp_host_inst (.clk(clk), .nrst(nrst), .link(link), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_q(rdata_q));
	lsp_device lsp_device_inst (.clk(clk), .nrst(nrst), .link(link), .setup_word_q(setup_word_q),
		.ref_word_q(ref_word_q), .ref_count_q(ref_count_q), .loop_word_q(loop_word_q),
		.load_pulse_q(load_pulse_q));
	lsp_checker lsp_checker_inst (.clk(clk), .nrst(nrst), .port_select_n(link.port_select_n),
		.serial_clock(link.serial_clock), .serial_data(link.serial_data),
		.setup_word_q(setup_word_q), .ref_word_q(ref_word_q), .ref_count_q(ref_count_q),
		.loop_word_q(loop_word_q), .load_pulse_q(load_pulse_q));
	// ************************************************************
	// clock, bus tasks and compare
	// ************************************************************
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata_q;
	endtask
	task automatic go(input logic [5:0] n, input logic [23:0] d);
		wr_reg(lsp_pkg::REG_DATA, {8'h00, d});
		wr_reg(lsp_pkg::REG_CTRL, {25'h000_0000, n, 1'b1});
		case (n) // model of the target chosen by the count
			6'h08: es = d[7:0];
			6'h10: er = d[15:0];
			6'h18: begin
				el = d;
				ec = er[12:0];
			end
			6'h00: ec = er[12:0];
			default: ; // other counts load nothing
		endcase
	endtask
	// bounded poll of busy, then room for the device pipeline to land
	task automatic finish_frame();
		int k;
		got = 32'h0000_0001;
		for (k = 0; k < 1000 && got[0] !== 1'b0; k++) rd_reg(lsp_pkg::REG_STATUS, got);
		if (got[0] !== 1'b0) failures++;
		repeat (12) @(posedge clk);
		cmp({24'h00_0000, setup_word_q}, {24'h00_0000, es});
		cmp({16'h0000, ref_word_q}, {16'h0000, er});
		cmp({19'h0_0000, ref_count_q}, {19'h0_0000, ec});
		cmp({8'h00, loop_word_q}, {8'h00, el});
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		{nrst, wr, rd, addr, wdata} = '0;
		{es, er, ec, el} = '0;
		failures = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		cmp({link.port_select_n, link.serial_clock, 30'h0000_0000}, 32'h8000_0000);
		finish_frame();
		for (i = 0; i < 9; i++) begin
			go(rows[i][29:24], rows[i][23:0]);
			finish_frame();
		end
		// a second order while busy is dropped, the first frame stands
		go(6'h08, 24'h00_0055);
		wr_reg(lsp_pkg::REG_DATA, 32'h0000_00aa);
		wr_reg(lsp_pkg::REG_CTRL, 32'h0000_0021);
		finish_frame();
		rd_reg(lsp_pkg::REG_DATA, got);
		cmp(got, 32'h0000_0055);
		rd_reg(lsp_pkg::REG_CTRL, got);
		cmp(got, 32'h0000_0008);
		// reset in mid-run brings every word back to zero
		@(posedge clk);
		nrst <= 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		{es, er, ec, el} = '0;
		finish_frame();
		rd_reg(4'hc, got);
		cmp(got, 32'h0000_0000);
		summarize();
	end
	initial begin
		#600000;
		failures++;
		summarize();
	end
endmodule // tb
